// [hw/pcs_consts.vh]
// constants for the palate contact scan interface
// assumes a 10 MHz clock and a classic wishbone register port
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// ==========================================================
// register offsets (byte addresses)
`define PCS_ADR_CTRL    8'h00
`define PCS_ADR_STATUS  8'h04
`define PCS_ADR_IRQ     8'h08
`define PCS_ADR_MASK    8'h0C
`define PCS_ADR_FRAME0  8'h10
`define PCS_ADR_LAST    8'h34

// ==========================================================
// control fields
`define PCS_CTRL_RUN    0
`define PCS_CTRL_PWR    1
`define PCS_CTRL_INJ    2
`define PCS_CTRL_PACE   3

// ==========================================================
// status and interrupt fields
`define PCS_IRQ_FRAME   0
`define PCS_IRQ_BATLOW  1
`define PCS_IRQ_FLOW    2
`define PCS_IRQ_W       3

// ==========================================================
// scan geometry
`define PCS_POS_FIRST   3'h1
`define PCS_POS_LAST    3'h5
`define PCS_WORDS       10
`define PCS_WORD_W      7

// ==========================================================
// settle time after an address change
`define PCS_SETTLE_NS   25000
`define PCS_CLK_NS      100

`endif

// [hw/pcs_scan.v]
// palate contact scanner: drives scan address, strobes 7-bit detector words, keeps one frame
// assumes the isolated front-end lines arrive asynchronously and a wishbone classic master on clk_i
// What this block does
// - drive a 4-bit scan address toward the isolated front end to pick the contact group.
// - for each address read one 7-bit contact word, one bit per multiplexer chip.
// - step the low bits through positions 1 to 5 only, gathering 35 contacts per half in five steps.
// - sample the contact word by asserting the active-low read strobe, and re-invert the active-low data lines when storing the word.
// - the injection tone reaches the hand electrode only while the active-low injection enable is asserted.
// - the front-end regulator supplies the front end only while power-up is asserted.
// - signals crossing the barrier are inverted, address and enables going out active low, battery-good returning active low.
// - take the display flow request as a logic input and use it to pace transmissions.
// - a complete frame is ten 7-bit words, one per scan step across both halves.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "pcs_consts.vh"

module pcs_scan #(
  parameter SETTLE_CYC = (`PCS_SETTLE_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // isolated front end (all active low across the barrier)
  output reg  [3:0]  scan_address_bits_n_o,
  output reg         front_power_up_n_o,
  output reg         injection_enable_n_o,
  output reg         contact_read_strobe_n_o,
  input  wire [6:0]  isolated_contact_lines_n_i,
  input  wire        battery_good_isolated_n_i,
  // display link pacing
  input  wire        display_flow_request_i,
  output reg         display_send_ok_o,
  // interrupt
  output reg         irq_o
);

  // ==========================================================
  // state encoding
  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_SETTLE = 4'b0010;
  localparam [3:0] ST_STROBE = 4'b0100;
  localparam [3:0] ST_STORE  = 4'b1000;

  localparam [15:0] SETTLE_LAST = SETTLE_CYC - 1;
  localparam [3:0]  WORD_LAST   = `PCS_WORDS - 1;

  // ==========================================================
  // input synchronisers
  reg  [6:0] cont_s1;
  reg  [6:0] cont_s2;
  reg        bat_s1;
  reg        bat_s2;
  reg        flow_s1;
  reg        flow_s2;
  reg        bat_d;
  reg        flow_d;

  always @(posedge clk_i) begin
    cont_s1 <= isolated_contact_lines_n_i;
    cont_s2 <= cont_s1;
    bat_s1  <= battery_good_isolated_n_i;
    bat_s2  <= bat_s1;
    flow_s1 <= display_flow_request_i;
    flow_s2 <= flow_s1;
  end

  // returned flag is active low across the barrier
  wire battery_good = ~bat_s2;

  // ==========================================================
  // registers
  reg [3:0]                ctrl;
  reg [`PCS_IRQ_W-1:0]     irq_stat;
  reg [`PCS_IRQ_W-1:0]     irq_mask;
  reg [`PCS_WORD_W-1:0]    frame [0:`PCS_WORDS-1];
  reg [3:0]                state;
  reg [15:0]               settle_cnt;
  reg                      half;
  reg [2:0]                pos;
  reg [3:0]                word_idx;
  reg [`PCS_WORD_W-1:0]    word_hold;
  reg [7:0]                frame_count;

  wire run    = ctrl[`PCS_CTRL_RUN];
  wire bus_rq = cyc_i & stb_i & ~ack_o;
  wire wr     = bus_rq & we_i & sel_i[0];

  // ==========================================================
  // scan sequencer
  wire frame_done = (state == ST_STORE) && (word_idx == WORD_LAST);

  always @(posedge clk_i) begin
    if (rst_i) begin
      state                   <= ST_IDLE;
      settle_cnt              <= 16'h0000;
      half                    <= 1'b0;
      pos                     <= `PCS_POS_FIRST;
      word_idx                <= 4'h0;
      word_hold               <= 7'h00;
      frame_count             <= 8'h00;
      contact_read_strobe_n_o <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          contact_read_strobe_n_o <= 1'b1;
          half       <= 1'b0;
          pos        <= `PCS_POS_FIRST;
          word_idx   <= 4'h0;
          settle_cnt <= 16'h0000;
          if (run && ctrl[`PCS_CTRL_PWR])
            state <= ST_SETTLE;
        end
        ST_SETTLE: begin
          // wait out the detector hold time so stale highs decay
          if (settle_cnt == SETTLE_LAST) begin
            settle_cnt              <= 16'h0000;
            contact_read_strobe_n_o <= 1'b0;
            state                   <= ST_STROBE;
          end else begin
            settle_cnt <= settle_cnt + 16'h0001;
          end
        end
        ST_STROBE: begin
          // strobe held two cycles; the synchronised data stored was sampled on the edge where the strobe falls
          state <= ST_STORE;
        end
        ST_STORE: begin
          contact_read_strobe_n_o <= 1'b1;
          word_hold               <= ~cont_s2;
          if (word_idx == WORD_LAST) begin
            frame_count <= frame_count + 8'h01;
            word_idx    <= 4'h0;
            half        <= 1'b0;
            pos         <= `PCS_POS_FIRST;
            state       <= run ? ST_SETTLE : ST_IDLE;
          end else begin
            word_idx <= word_idx + 4'h1;
            if (pos == `PCS_POS_LAST) begin
              pos  <= `PCS_POS_FIRST;
              half <= ~half;
            end else begin
              pos <= pos + 3'h1;
            end
            state <= ST_SETTLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // frame memory written in the cycle after the store decision
  reg       store_d;
  reg [3:0] store_idx;
  always @(posedge clk_i) begin
    if (rst_i) begin
      store_d   <= 1'b0;
      store_idx <= 4'h0;
    end else begin
      store_d   <= (state == ST_STORE);
      store_idx <= word_idx;
    end
    if (store_d)
      frame[store_idx] <= word_hold;
  end

  // ==========================================================
  // outputs toward the front end, inverted across the barrier, and the display send permission
  always @(posedge clk_i) begin
    if (rst_i) begin
      scan_address_bits_n_o <= 4'hF;
      front_power_up_n_o    <= 1'b1;
      injection_enable_n_o  <= 1'b1;
      display_send_ok_o     <= 1'b0;
    end else begin
      scan_address_bits_n_o <= ~{half, pos};
      front_power_up_n_o    <= ~ctrl[`PCS_CTRL_PWR];
      injection_enable_n_o  <= ~ctrl[`PCS_CTRL_INJ];
      display_send_ok_o     <= ~ctrl[`PCS_CTRL_PACE] | flow_s2;
    end
  end

  // ==========================================================
  // interrupt events: set wins over write-one-to-clear
  wire [`PCS_IRQ_W-1:0] irq_ev;
  assign irq_ev[`PCS_IRQ_FRAME]  = frame_done;
  assign irq_ev[`PCS_IRQ_BATLOW] = bat_d & ~battery_good;
  assign irq_ev[`PCS_IRQ_FLOW]   = ~flow_d & flow_s2;

  wire [`PCS_IRQ_W-1:0] irq_clr = (wr && adr_i == `PCS_ADR_IRQ) ? dat_i[`PCS_IRQ_W-1:0] : {`PCS_IRQ_W{1'b0}};

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= {`PCS_IRQ_W{1'b0}};
      irq_o    <= 1'b0;
      bat_d    <= 1'b0;
      flow_d   <= 1'b0;
    end else begin
      bat_d    <= battery_good;
      flow_d   <= flow_s2;
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      irq_o    <= |(((irq_stat & ~irq_clr) | irq_ev) & irq_mask);
    end
  end

  // ==========================================================
  // wishbone slave: ack one cycle after the request, unmapped reads zero
  reg [31:0] next_dat;
  wire [3:0] rd_idx = adr_i[5:2] - 4'h4;

  always @* begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      `PCS_ADR_CTRL:   next_dat = {28'h0, ctrl};
      `PCS_ADR_STATUS: next_dat = {16'h0, frame_count, 2'b00, flow_s2, battery_good, state};
      `PCS_ADR_IRQ:    next_dat = {29'h0, irq_stat};
      `PCS_ADR_MASK:   next_dat = {29'h0, irq_mask};
      default: begin
        if (adr_i >= `PCS_ADR_FRAME0 && adr_i <= `PCS_ADR_LAST && adr_i[1:0] == 2'b00)
          next_dat = {25'h0, frame[rd_idx]};
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      dat_o    <= 32'h0000_0000;
      ctrl     <= 4'h0;
      irq_mask <= {`PCS_IRQ_W{1'b0}};
    end else begin
      ack_o <= bus_rq;
      dat_o <= bus_rq ? next_dat : 32'h0000_0000;
      if (wr && adr_i == `PCS_ADR_CTRL)
        ctrl <= dat_i[3:0];
      if (wr && adr_i == `PCS_ADR_MASK)
        irq_mask <= dat_i[`PCS_IRQ_W-1:0];
    end
  end

endmodule // pcs_scan

// [test/pcs_front_model.sv]
// isolated front end: multiplexer boards and detectors seen through the barrier
// assumes contact pattern {half, pos, ~pos} under scan positions 1 to 5
`timescale 1ns/10ps
module pcs_front_model (
  // from the scanner, active low
  input  wire [3:0] addr_n_i,
  input  wire       pwr_n_i,
  input  wire       inj_n_i,
  // back toward the scanner, active low
  output wire [6:0] lines_n_o
);
  wire [3:0] a    = ~addr_n_i;
  wire       live = !pwr_n_i && !inj_n_i;
  wire [6:0] word = {a[3], a[2:0], ~a[2:0]};
  // grounded positions and a dead front end read as no contact
  assign lines_n_o = (live && a[2:0] >= 3'h1 && a[2:0] <= 3'h5) ? ~word : 7'h7F;
endmodule // pcs_front_model

// [test/pcs_scan_checker.sv]
// assertions on the scan interface pins and its wishbone port
// assumes it is bound to pcs_scan and sees only its ports
`timescale 1ns/10ps
`include "pcs_consts.vh"
module pcs_scan_checker #(
  parameter SETTLE_CYC = 250
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire [3:0]  scan_address_bits_n_o,
  input wire        front_power_up_n_o,
  input wire        injection_enable_n_o,
  input wire        contact_read_strobe_n_o,
  input wire        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int since;
  // the change is seen one edge late, so that edge already counts as one cycle of settling
  always @(posedge clk_i) since <= $changed(scan_address_bits_n_o) ? 1 : since + 1;
  sequence strobe_tail; !contact_read_strobe_n_o ##1 contact_read_strobe_n_o; endsequence
  sequence ctrl_write; cyc_i && stb_i && ack_o && we_i && adr_i == `PCS_ADR_CTRL && sel_i[0]; endsequence
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  chk_strobe_width: assert property ($fell(contact_read_strobe_n_o) |=> strobe_tail)
    else $error("strobe not two cycles");
  chk_addr_hold: assert property (!contact_read_strobe_n_o |-> $stable(scan_address_bits_n_o))
    else $error("address moved under strobe");
  chk_pos_range: assert property (!contact_read_strobe_n_o |->
    (~scan_address_bits_n_o[2:0]) inside {[`PCS_POS_FIRST:`PCS_POS_LAST]}) else $error("grounded position read");
  chk_settle_wait: assert property ($fell(contact_read_strobe_n_o) |-> since >= SETTLE_CYC - 1)
    else $error("strobe before settle");
  chk_ctrl_pins: assert property (ctrl_write |-> ##2
    {injection_enable_n_o, front_power_up_n_o} == ~$past(dat_i[2:1], 2)) else $error("enables not inverted");
  chk_reset_state: assert property (disable iff (1'b0) rst_i |=> scan_address_bits_n_o == 4'hF
    && front_power_up_n_o && injection_enable_n_o && contact_read_strobe_n_o && !irq_o && !ack_o)
    else $error("bad reset state");
endmodule // pcs_scan_checker
bind pcs_scan pcs_scan_checker #(.SETTLE_CYC(SETTLE_CYC)) pcs_scan_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .scan_address_bits_n_o(scan_address_bits_n_o), .front_power_up_n_o(front_power_up_n_o),
  .injection_enable_n_o(injection_enable_n_o), .contact_read_strobe_n_o(contact_read_strobe_n_o), .irq_o(irq_o));

// [test/tb.sv]
// self-checking bench: registers, one full frame, battery and flow events
// assumes pcs_front_model as the front end and a short settle time
`timescale 1ns/10ps
`include "pcs_consts.vh"
module tb;
  reg         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, bat_n = 1'b0, flow = 1'b0;
  reg  [7:0]  adr_i = 8'h00;
  reg  [3:0]  sel_i = 4'hF;
  reg  [31:0] dat_i = 32'h0, rd;
  wire [31:0] dat_o;
  wire [6:0]  lines_n;
  wire [3:0]  addr_n;
  wire        ack_o, pwr_n, inj_n, strobe_n, send_ok, irq_o;
  integer     fail_count = 0, compares = 0, i;
  initial forever #50 clk_i = ~clk_i;
  pcs_scan #(.SETTLE_CYC(4)) pcs_scan_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .scan_address_bits_n_o(addr_n), .front_power_up_n_o(pwr_n), .injection_enable_n_o(inj_n),
    .contact_read_strobe_n_o(strobe_n), .isolated_contact_lines_n_i(lines_n), .battery_good_isolated_n_i(bat_n),
    .display_flow_request_i(flow), .display_send_ok_o(send_ok), .irq_o(irq_o));
  pcs_front_model pcs_front_model_inst (.addr_n_i(addr_n), .pwr_n_i(pwr_n), .inj_n_i(inj_n), .lines_n_o(lines_n));
  task conclude;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input string name, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s expected %0h seen %0h", name, exp, got);
      end
    end
  endtask
  // lim is the cycle budget; running out ends the run
  task wait_ack(input integer lim, input sig_irq);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while ((sig_irq ? irq_o : ack_o) !== 1'b1 && n < lim);
      if ((sig_irq ? irq_o : ack_o) !== 1'b1) begin
        fail_count = fail_count + 1;
        conclude;
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      wait_ack(20, 1'b0);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  function [6:0] exp_word(input integer k);
    reg [2:0] p;
    begin
      p = k % 5 + 1;
      exp_word = {k >= 5, p, ~p};
    end
  endfunction
  task scen_reset;
    begin
      check("address", 4'hF, addr_n);
      check("power", 1, pwr_n);
      wb(1'b0, 8'hFC, 0);
      check("unmapped", 0, rd);
    end
  endtask
  task scen_frame;
    begin
      wb(1'b1, `PCS_ADR_MASK, 32'h1);
      wb(1'b1, `PCS_ADR_CTRL, 32'h7);
      wait_ack(400, 1'b1);
      check("power on", 0, pwr_n);
      check("inject on", 0, inj_n);
      wb(1'b1, `PCS_ADR_CTRL, 32'h6);
      repeat (200) @(posedge clk_i);
      wb(1'b1, `PCS_ADR_IRQ, 32'h7);
      repeat (2) @(posedge clk_i);
      check("irq cleared", 0, irq_o);
      for (i = 0; i < 10; i = i + 1) begin
        wb(1'b0, 8'(`PCS_ADR_FRAME0 + 4 * i), 0);
        check("word", exp_word(i), rd);
      end
    end
  endtask
  task scen_events;
    begin
      wb(1'b1, `PCS_ADR_MASK, 32'h2);
      bat_n <= 1'b1;
      wait_ack(40, 1'b1);
      wb(1'b0, `PCS_ADR_IRQ, 0);
      check("battery event", 32'h2, rd);
      wb(1'b0, `PCS_ADR_STATUS, 0);
      check("status", 32'h0000_0201, rd);
      wb(1'b1, `PCS_ADR_MASK, 0);
      repeat (2) @(posedge clk_i);
      check("masked irq", 0, irq_o);
      wb(1'b1, `PCS_ADR_CTRL, 32'h8);
      flow <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("send ok", 1, send_ok);
      flow <= 1'b0;
      repeat (4) @(posedge clk_i);
      check("send held", 0, send_ok);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    scen_reset;
    scen_frame;
    scen_events;
    conclude;
  end
endmodule // tb
